/* rtl/jdm_dtc_manager.sv */
// trouble code manager: fault qualification, code lists, DM1 scheduling, AXI4-Lite setup
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "jdm_consts.svh"
module jdm_dtc_manager #(
    parameter int NF = 120,
    parameter int unsigned MS_CYCLES = `JDM_MS_NS / `JDM_CLK_NS,
    parameter int unsigned PERIOD_CYCLES = `JDM_DM1_PERIOD_MS * (`JDM_MS_NS / `JDM_CLK_NS),
    parameter int unsigned STARTUP_CYCLES = `JDM_STARTUP_MS * (`JDM_MS_NS / `JDM_CLK_NS)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [NF-1:0] fault_flags,
    input wire jdm_pkg::jdm_req_t req,
    output logic req_ready,
    output jdm_pkg::jdm_dtc_t dtc,
    output jdm_pkg::jdm_hdr_t hdr,
    output jdm_pkg::jdm_nv_t nv,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    localparam int IW = $clog2(NF);

    typedef struct packed {
        logic [NF-1:0][18:0] spn;
        logic [NF-1:0][4:0] fmi;
        logic [NF-1:0] en;
        logic [NF-1:0] latch;
        logic [NF-1:0] hi;
        logic [NF-1:0][1:0] lamp;
        logic [NF-1:0][15:0] dly;
        logic [NF-1:0][6:0] occ;
        logic [NF-1:0] act;
        logic [NF-1:0] prev;
        logic [NF-1:0] qrun;
        logic [NF-1:0][15:0] tmr;
        logic [1:0] pol1;
        logic [1:0] pol2;
        logic [IW-1:0] sel;
        logic [IW-1:0] idx;
        jdm_pkg::jdm_sweep_t mode;
        logic tp;
        logic [7:0] dest;
        logic clr11;
        logic clr3;
        logic tick_now;
        logic [7:0] cnt;
        logic [7:0] lamp_acc;
        logic [7:0] act_acc;
        logic any_acc;
        logic any_en;
        logic [7:0] act_cnt;
        logic [31:0] ms_cnt;
        logic [31:0] per_cnt;
        logic [31:0] up_cnt;
        logic up_done;
        logic tick_pend;
        logic per_pend;
        logic evt_pend;
        logic req_pend;
        jdm_pkg::jdm_req_kind_t req_kind;
        logic [7:0] req_src;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic req_ready;
        jdm_pkg::jdm_dtc_t dtc;
        jdm_pkg::jdm_hdr_t hdr;
        jdm_pkg::jdm_nv_t nv;
    } jdm_state_t;

    function automatic jdm_state_t rst_state();
        jdm_state_t s;
        s = '0;
        for (int k = 0; k < NF; k++)
        begin
            s.spn[k] = 19'(`JDM_SPN_BASE + k);
            s.fmi[k] = `JDM_FMI_RST;
            s.lamp[k] = `JDM_LAMP_RST;
            s.dly[k] = `JDM_DLY_RST;
        end
        s.pol1 = `JDM_POL_RST;
        s.pol2 = `JDM_POL_RST;
        s.dest = `JDM_DEST_GLOBAL;
        s.awready = 1'b1;
        s.wready = 1'b1;
        s.arready = 1'b1;
        s.req_ready = 1'b1;
        return s;
    endfunction

    localparam jdm_state_t RST = rst_state();

    function automatic logic [4:0] hi_fmi(input logic [4:0] f);
        case (f)
            5'h01: hi_fmi = 5'h00;
            5'h04: hi_fmi = 5'h03;
            5'h05: hi_fmi = 5'h06;
            5'h11: hi_fmi = 5'h0F;
            5'h12: hi_fmi = 5'h10;
            5'h15: hi_fmi = 5'h14;
            default: hi_fmi = f;
        endcase
    endfunction

    // lamp on = 2'b01 in its field: malfunction 7:6, red 5:4, amber 3:2, protect 1:0
    function automatic logic [7:0] lamp_bits(input logic [1:0] s);
        case (s)
            2'h0: lamp_bits = 8'h40;
            2'h1: lamp_bits = 8'h10;
            2'h2: lamp_bits = 8'h04;
            default: lamp_bits = 8'h01;
        endcase
    endfunction

    // blank parameter number is zero; the no-faults message counts as blank
    function automatic logic pol_ok(input logic [1:0] p, input logic blank);
        pol_ok = (p == `JDM_POL_NORMAL) || (p == `JDM_POL_NONBLANK && !blank);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] b);
        for (int k = 0; k < 4; k++)
        begin
            merge[8*k +: 8] = b[k] ? d[8*k +: 8] : o[8*k +: 8];
        end
    endfunction

    jdm_state_t q;
    jdm_state_t n;
    logic wr_exec;
    logic sel_ok;
    logic f;
    logic [IW-1:0] i;
    logic [31:0] cfg_rd;
    logic [31:0] wv;
    logic [31:0] rd;
    logic [7:0] cnt_v;
    logic [7:0] lamp_v;
    logic [7:0] act_v;
    logic any_v;
    logic [4:0] fe;

    always_comb
    begin
        n = q;
        n.dtc.valid = 1'b0;
        n.hdr.valid = 1'b0;
        n.nv.valid = 1'b0;
        wr_exec = q.aw_got && q.w_got && !q.bvalid;
        sel_ok = int'(q.sel) < NF;
        cfg_rd = '0;
        if (sel_ok)
        begin
            cfg_rd = {3'h0, q.hi[q.sel], q.lamp[q.sel], q.latch[q.sel], q.en[q.sel],
                      q.fmi[q.sel], q.spn[q.sel]};
        end
        wv = merge(q.awaddr == `JDM_REG_CFG ? cfg_rd : 32'h00000000, q.wdata, q.wstrb);
        if (awvalid && q.awready)
        begin
            n.aw_got = 1'b1;
            n.awaddr = awaddr;
        end
        if (wvalid && q.wready)
        begin
            n.w_got = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (q.bvalid && bready)
        begin
            n.bvalid = 1'b0;
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
        end
        if (wr_exec)
        begin
            n.bvalid = 1'b1;
            n.bresp = `JDM_RESP_OKAY;
            case (q.awaddr)
                `JDM_REG_CTRL:
                begin
                    if (q.wstrb[0])
                    begin
                        n.pol1 = q.wdata[1:0];
                        n.pol2 = q.wdata[3:2];
                    end
                end
                `JDM_REG_STATUS: ;
                `JDM_REG_SEL:
                begin
                    if (q.wstrb[0])
                    begin
                        n.sel = q.wdata[IW-1:0];
                    end
                end
                `JDM_REG_CFG:
                begin
                    if (sel_ok)
                    begin
                        n.spn[q.sel] = wv[`JDM_CFG_SPN_LSB +: 19];
                        n.fmi[q.sel] = wv[`JDM_CFG_FMI_LSB +: 5];
                        n.en[q.sel] = wv[`JDM_CFG_EN_BIT];
                        n.latch[q.sel] = wv[`JDM_CFG_LATCH_BIT];
                        n.lamp[q.sel] = wv[`JDM_CFG_LAMP_LSB +: 2];
                        n.hi[q.sel] = wv[`JDM_CFG_HI_BIT];
                        if (wv[`JDM_CFG_SPN_LSB +: 19] != q.spn[q.sel]
                            || wv[`JDM_CFG_FMI_LSB +: 5] != q.fmi[q.sel])
                        begin
                            n.occ[q.sel] = 7'h00;
                            n.nv = '{valid: 1'b1, clr: 1'b1, idx: 7'(q.sel), count: 7'h00};
                        end
                    end
                end
                `JDM_REG_DELAY:
                begin
                    if (sel_ok)
                    begin
                        n.dly[q.sel] = 16'(merge({16'h0000, q.dly[q.sel]}, q.wdata, q.wstrb));
                    end
                end
                `JDM_REG_FSTAT:
                begin
                    // software restores saved counts here after power-up
                    if (sel_ok && q.wstrb[0])
                    begin
                        n.occ[q.sel] = q.wdata[6:0];
                    end
                end
                default: n.bresp = `JDM_RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        rd = '0;
        n.rresp = `JDM_RESP_OKAY;
        case (araddr)
            `JDM_REG_CTRL: rd = {28'h0000000, q.pol2, q.pol1};
            `JDM_REG_STATUS: rd = {22'h000000, q.any_en, q.up_done, q.act_cnt};
            `JDM_REG_SEL: rd = 32'(q.sel);
            `JDM_REG_CFG: rd = cfg_rd;
            `JDM_REG_DELAY: rd = sel_ok ? {16'h0000, q.dly[q.sel]} : 32'h00000000;
            `JDM_REG_FSTAT: rd = sel_ok ? {21'h000000, q.qrun[q.sel], q.prev[q.sel],
                                           q.act[q.sel], 1'b0, q.occ[q.sel]} : 32'h00000000;
            default: n.rresp = `JDM_RESP_SLVERR;
        endcase
        if (!(arvalid && q.arready))
        begin
            n.rresp = q.rresp;
        end
        if (q.rvalid && rready)
        begin
            n.rvalid = 1'b0;
        end
        if (arvalid && q.arready)
        begin
            n.rvalid = 1'b1;
            n.rdata = rd;
        end
        n.arready = !n.rvalid;

        if (!q.up_done)
        begin
            if (q.up_cnt == STARTUP_CYCLES - 1)
            begin
                n.up_done = 1'b1;
            end
            else
            begin
                n.up_cnt = q.up_cnt + 32'h00000001;
            end
        end
        if (q.ms_cnt == MS_CYCLES - 1)
        begin
            n.ms_cnt = '0;
            n.tick_pend = 1'b1;
        end
        else
        begin
            n.ms_cnt = q.ms_cnt + 32'h00000001;
        end
        if (q.per_cnt == PERIOD_CYCLES - 1)
        begin
            n.per_cnt = '0;
            n.per_pend = n.per_pend || q.any_en;
        end
        else
        begin
            n.per_cnt = q.per_cnt + 32'h00000001;
        end
        if (req.valid && q.req_ready)
        begin
            n.req_pend = 1'b1;
            n.req_kind = req.kind;
            n.req_src = req.src;
        end

        // one fault per cycle; stalls while a register write lands so nv has one writer
        i = q.idx;
        f = fault_flags[i];
        cnt_v = q.cnt;
        lamp_v = q.lamp_acc;
        act_v = q.act_acc;
        any_v = q.any_acc || q.en[i];
        fe = q.hi[i] ? hi_fmi(q.fmi[i]) : q.fmi[i];
        if (!wr_exec)
        begin
            if (!q.en[i])
            begin
                n.act[i] = 1'b0;
                n.qrun[i] = 1'b0;
            end
            else
            begin
                if (q.clr3 && q.prev[i] && !q.act[i])
                begin
                    n.prev[i] = 1'b0;
                    n.occ[i] = 7'h00;
                    n.nv = '{valid: 1'b1, clr: 1'b1, idx: 7'(i), count: 7'h00};
                end
                if (q.act[i])
                begin
                    act_v = act_v + 8'h01;
                    if ((!f && !q.latch[i]) || q.clr11)
                    begin
                        n.act[i] = 1'b0;
                        n.prev[i] = 1'b1;
                        n.evt_pend = 1'b1;
                    end
                end
                else if (f)
                begin
                    if (!q.qrun[i])
                    begin
                        n.qrun[i] = 1'b1;
                        n.tmr[i] = q.dly[i];
                    end
                    else if (q.tmr[i] == 16'h0000)
                    begin
                        n.qrun[i] = 1'b0;
                        n.act[i] = 1'b1;
                        n.occ[i] = (q.occ[i] == `JDM_OCC_MAX) ? q.occ[i]
                                   : q.occ[i] + 7'h01;
                        n.nv = '{valid: 1'b1, clr: 1'b0, idx: 7'(i), count: n.occ[i]};
                        n.evt_pend = 1'b1;
                    end
                    else if (q.tick_now)
                    begin
                        n.tmr[i] = q.tmr[i] - 16'h0001;
                    end
                end
                else
                begin
                    n.qrun[i] = 1'b0;
                end
                if ((q.mode == jdm_pkg::JDM_SW_DM1 && q.act[i])
                    || (q.mode == jdm_pkg::JDM_SW_DM2 && q.prev[i] && !q.act[i]))
                begin
                    n.dtc.valid = 1'b1;
                    n.dtc.word = {q.occ[i], 1'b0, fe, q.spn[i]};
                    n.dtc.if_en = {pol_ok(q.pol2, q.spn[i] == 19'h00000),
                                   pol_ok(q.pol1, q.spn[i] == 19'h00000)};
                    cnt_v = cnt_v + 8'h01;
                    lamp_v = lamp_v | lamp_bits(q.lamp[i]);
                end
            end
            n.cnt = cnt_v;
            n.lamp_acc = lamp_v;
            n.act_acc = act_v;
            n.any_acc = any_v;
            n.idx = i + IW'(1);
            if (int'(i) == NF - 1)
            begin
                n.idx = '0;
                n.act_cnt = act_v;
                n.any_en = any_v;
                if (q.mode != jdm_pkg::JDM_SW_SCAN)
                begin
                    n.hdr.valid = 1'b1;
                    n.hdr.dm2 = q.mode == jdm_pkg::JDM_SW_DM2;
                    n.hdr.reqd = q.tp || q.mode == jdm_pkg::JDM_SW_DM2;
                    n.hdr.lamp = lamp_v;
                    n.hdr.count = cnt_v;
                    n.hdr.dest = q.dest;
                    n.hdr.if_en = {pol_ok(q.pol2, cnt_v == 8'h00),
                                   pol_ok(q.pol1, cnt_v == 8'h00)};
                    if (cnt_v == 8'h00)
                        n.hdr.kind = jdm_pkg::JDM_MSG_NOFAULT;
                    else if (cnt_v == 8'h01)
                        n.hdr.kind = jdm_pkg::JDM_MSG_SINGLE;
                    else if (n.hdr.reqd)
                        n.hdr.kind = jdm_pkg::JDM_MSG_TP;
                    else
                        n.hdr.kind = jdm_pkg::JDM_MSG_BAM;
                end
                n.cnt = 8'h00;
                n.lamp_acc = 8'h00;
                n.act_acc = 8'h00;
                n.any_acc = 1'b0;
                n.mode = jdm_pkg::JDM_SW_SCAN;
                n.tp = 1'b0;
                n.dest = `JDM_DEST_GLOBAL;
                n.clr3 = 1'b0;
                n.clr11 = 1'b0;
                n.tick_now = n.tick_pend;
                n.tick_pend = 1'b0;
                // broadcasts go first so a stream of requests cannot starve them
                if (!q.up_done)
                begin
                    n.per_pend = 1'b0;
                    n.evt_pend = 1'b0;
                end
                if (q.up_done && any_v && (n.per_pend || n.evt_pend))
                begin
                    n.mode = jdm_pkg::JDM_SW_DM1;
                    n.per_pend = 1'b0;
                    n.evt_pend = 1'b0;
                end
                else if (q.req_pend)
                begin
                    n.req_pend = 1'b0;
                    n.dest = q.req_src;
                    case (q.req_kind)
                        jdm_pkg::JDM_REQ_DM1:
                        begin
                            n.mode = jdm_pkg::JDM_SW_DM1;
                            n.tp = 1'b1;
                        end
                        jdm_pkg::JDM_REQ_DM2: n.mode = jdm_pkg::JDM_SW_DM2;
                        jdm_pkg::JDM_REQ_DM3: n.clr3 = 1'b1;
                        jdm_pkg::JDM_REQ_DM11: n.clr11 = 1'b1;
                        default: ;
                    endcase
                end
            end
        end
        n.req_ready = !n.req_pend;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= RST;
        else if (ce)
            q <= n;
    end

    assign req_ready = q.req_ready;
    assign dtc = q.dtc;
    assign hdr = q.hdr;
    assign nv = q.nv;
    assign awready = q.awready;
    assign wready = q.wready;
    assign bresp = q.bresp;
    assign bvalid = q.bvalid;
    assign arready = q.arready;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign rvalid = q.rvalid;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    sequence s_sweep_hdr;
        ##[1:400] q.hdr.valid;
    endsequence

    a_cm_bit_zero: assert property (q.dtc.valid |-> q.dtc.word[24] == 1'b0)
        else $error("conversion bit set in code word");
    a_event_send: assert property (q.evt_pend && q.up_done && q.any_en |-> s_sweep_hdr)
        else $error("event did not produce a DM1");
    a_startup_quiet: assert property (q.hdr.valid && !q.hdr.reqd |-> $past(q.up_done))
        else $error("broadcast before startup delay");
    a_nofault_kind: assert property (q.hdr.valid && q.hdr.count == 8'h00
                                     |-> q.hdr.kind == jdm_pkg::JDM_MSG_NOFAULT)
        else $error("empty DM1 not marked no faults");
    a_multi_kind: assert property (q.hdr.valid && q.hdr.count > 8'h01 |-> q.hdr.kind
        == (q.hdr.reqd ? jdm_pkg::JDM_MSG_TP : jdm_pkg::JDM_MSG_BAM))
        else $error("multipacket kind wrong");
    a_policy_off: assert property (q.hdr.valid && q.pol1 == `JDM_POL_OFF
                                   |-> !q.hdr.if_en[0])
        else $error("diagnostics sent on disabled interface");
    a_occ_nowrap: assert property (q.nv.valid && !q.nv.clr |-> q.nv.count != 7'h00)
        else $error("occurrence count wrapped");
    a_bresp_hold: assert property (q.bvalid && !bready |=> q.bvalid && $stable(q.bresp))
        else $error("write response dropped");
endmodule

/* rtl/jdm_consts.svh */
// constants for the trouble code manager: offsets, fields, reset values, timing
// Summary of operation
// - code word is 19-bit SPN from bit 0, 5-bit FMI, zero CM bit, 7-bit count
// - one hundred twenty independent fault sources, each able to give its own code
// - a fault's settings act only while its reporting enable is set
// - DM1 goes out every second while any fault reports, active or not
// - with nothing active the periodic DM1 carries the no-active-faults content
// - a code turning inactive triggers an immediate extra DM1
// - when the last code goes inactive a DM1 shows none remain
// - more than one active code: periodic DM1 goes out as announced multipacket
// - DM1 request with several codes active: multipacket sent to requester by connection
// - no DM1 broadcast during the first five seconds after power-up
// - DM2 answers and DM3 and DM11 clears happen only on request
// - without latching a code goes previously active once its condition ends
// - with latching a code stays active until a DM11 request arrives
// - DM1 first byte lights the lamp chosen by each active fault
// - writing a new parameter number clears that fault's occurrence count
// - writing a new failure mode clears that fault's occurrence count
// - high side of a two-sided fault uses the paired failure mode code
// - unpaired failure mode: both sides report it but keep separate counts
// - occurrence counts are kept in non-volatile storage outside the block
// - new fault counts down its qualify delay before going active and counting
// - a newly qualified code triggers an immediate DM1
// - each CAN interface has a policy: off, non-blank only, or normal
`ifndef JDM_CONSTS_SVH
`define JDM_CONSTS_SVH

`define JDM_REG_CTRL 8'h00
`define JDM_REG_STATUS 8'h04
`define JDM_REG_SEL 8'h08
`define JDM_REG_CFG 8'h0C
`define JDM_REG_DELAY 8'h10
`define JDM_REG_FSTAT 8'h14

`define JDM_CFG_SPN_LSB 0
`define JDM_CFG_FMI_LSB 19
`define JDM_CFG_EN_BIT 24
`define JDM_CFG_LATCH_BIT 25
`define JDM_CFG_LAMP_LSB 26
`define JDM_CFG_HI_BIT 28
`define JDM_FST_ACT_BIT 8
`define JDM_FST_PREV_BIT 9
`define JDM_FST_QRUN_BIT 10
`define JDM_ST_UP_BIT 8
`define JDM_ST_ANY_BIT 9

`define JDM_SPN_BASE 32'h0007F000
`define JDM_FMI_RST 5'h0E
`define JDM_LAMP_RST 2'h2
`define JDM_DLY_RST 16'h0064
`define JDM_POL_RST 2'h2

`define JDM_POL_OFF 2'h0
`define JDM_POL_NONBLANK 2'h1
`define JDM_POL_NORMAL 2'h2

`define JDM_RESP_OKAY 2'h0
`define JDM_RESP_SLVERR 2'h2
`define JDM_DEST_GLOBAL 8'hFF
`define JDM_OCC_MAX 7'h7F

`define JDM_CLK_NS 10
`define JDM_MS_NS 1000000
`define JDM_DM1_PERIOD_MS 1000
`define JDM_STARTUP_MS 5000

`endif

/* rtl/jdm_pkg.sv */
// types shared by the trouble code manager and its users
package jdm_pkg;
    typedef enum logic [1:0] {JDM_REQ_DM1, JDM_REQ_DM2, JDM_REQ_DM3, JDM_REQ_DM11} jdm_req_kind_t;
    typedef enum logic [1:0] {JDM_MSG_NOFAULT, JDM_MSG_SINGLE, JDM_MSG_BAM, JDM_MSG_TP} jdm_msg_t;
    typedef enum logic [1:0] {JDM_SW_SCAN, JDM_SW_DM1, JDM_SW_DM2} jdm_sweep_t;

    typedef struct packed {
        logic valid;
        jdm_req_kind_t kind;
        logic [7:0] src;
    } jdm_req_t;

    typedef struct packed {
        logic valid;
        logic [1:0] if_en;
        logic [31:0] word;
    } jdm_dtc_t;

    typedef struct packed {
        logic valid;
        jdm_msg_t kind;
        logic dm2;
        logic reqd;
        logic [7:0] lamp;
        logic [7:0] count;
        logic [7:0] dest;
        logic [1:0] if_en;
    } jdm_hdr_t;

    typedef struct packed {
        logic valid;
        logic clr;
        logic [6:0] idx;
        logic [6:0] count;
    } jdm_nv_t;
endpackage

/* tb/jdm_net_model.sv */
// far node: issues diagnostic requests
`timescale 1ns/1ns
module jdm_net_model (
    input wire logic aclk,
    input wire logic send,
    input wire jdm_pkg::jdm_req_kind_t kind,
    input wire logic [7:0] src,
    input wire logic req_ready,
    output jdm_pkg::jdm_req_t req
);
    initial req = '0;
    // held until taken
    always @(posedge aclk)
    begin
        if (req.valid && req_ready)
            req.valid <= 1'b0;
        else if (send)
            req <= '{1'b1, kind, src};
    end
endmodule

/* tb/jdm_dtc_manager_tb.sv */
// self-checking bench for the trouble code manager
`timescale 1ns/1ns
module jdm_dtc_manager_tb;
    logic aclk = 0, aresetn = 0, send = 0, awvalid = 0, wvalid = 0;
    logic bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic req_ready;
    logic [7:0] awaddr = '0, araddr = '0, rq_src = 8'h33;
    logic [31:0] wdata = '0, rd, dtc_word, rdata;
    logic [1:0] rs, bresp, rresp;
    logic [119:0] fault_flags = '0;
    jdm_pkg::jdm_req_kind_t rq_kind = jdm_pkg::JDM_REQ_DM1;
    jdm_pkg::jdm_req_t req;
    jdm_pkg::jdm_dtc_t dtc;
    jdm_pkg::jdm_nv_t nv, nv_last;
    jdm_pkg::jdm_hdr_t hdr, last_hdr;
    int failures = 0, samples_checked = 0, cycles = 0, hdr_cnt = 0;
    always #5 aclk = ~aclk;
    // startup longer than one period so a first periodic slot falls inside it
    jdm_dtc_manager #(.MS_CYCLES(4), .PERIOD_CYCLES(2000), .STARTUP_CYCLES(2500)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .fault_flags(fault_flags),
        .req(req), .req_ready(req_ready), .dtc(dtc), .hdr(hdr), .nv(nv),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    jdm_net_model i_net (.aclk(aclk), .send(send), .kind(rq_kind), .src(rq_src),
        .req_ready(req_ready), .req(req));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        // bready stays up so back-to-back calls never re-drive it in one step
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask
    // zero qualify delay keeps the run short
    task automatic cfg(input logic [7:0] idx, input logic [31:0] w);
        axi_wr(8'h08, {24'h0, idx});
        axi_wr(8'h0C, w);
        axi_wr(8'h10, 32'h0);
    endtask
    task automatic request(input jdm_pkg::jdm_req_kind_t k);
        rq_kind <= k;
        send <= 1'b1;
        @(posedge aclk);
        send <= 1'b0;
    endtask
    task automatic wait_hdr(input jdm_pkg::jdm_msg_t k);
        int n;
        n = hdr_cnt;
        do
        begin
            @(posedge aclk);
        end while (!(hdr_cnt > n && last_hdr.kind === k));
    endtask
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (dtc.valid === 1'b1)
            dtc_word <= dtc.word;
        if (nv.valid === 1'b1)
            nv_last <= nv;
        if (hdr.valid === 1'b1)
        begin
            last_hdr <= hdr;
            hdr_cnt <= hdr_cnt + 1;
        end
        if (cycles == 40000)
        begin
            failures++;
            give_verdict;
        end
    end
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(8'h0C, rd, rs);
        check(rd, 32'h0877F000);
        axi_rd(8'h18, rd, rs);
        check({30'h0, rs}, 32'h2);
        cfg(8'h03, 32'h05212345);
        // restored count at the ceiling: the next qualify must not wrap
        axi_wr(8'h14, 32'h7F);
        cfg(8'h04, 32'h19200022);
        rd = '0;
        while (rd[8] !== 1'b1)
            axi_rd(8'h04, rd, rs);
        check(hdr_cnt, 0);
        wait_hdr(jdm_pkg::JDM_MSG_NOFAULT);
        @(posedge aclk);
        fault_flags[3] <= 1'b1;
        wait_hdr(jdm_pkg::JDM_MSG_SINGLE);
        check(dtc_word, 32'hFE212345);
        check(last_hdr.lamp, 8'h10);
        @(posedge aclk);
        fault_flags[4] <= 1'b1;
        wait_hdr(jdm_pkg::JDM_MSG_BAM);
        check(dtc_word, 32'h02180022);
        check(last_hdr.lamp, 8'h14);
        request(jdm_pkg::JDM_REQ_DM1);
        wait_hdr(jdm_pkg::JDM_MSG_TP);
        check(last_hdr.dest, 8'h33);
        @(posedge aclk);
        fault_flags[4] <= 1'b0;
        wait_hdr(jdm_pkg::JDM_MSG_SINGLE);
        @(posedge aclk);
        fault_flags[3] <= 1'b0;
        wait_hdr(jdm_pkg::JDM_MSG_NOFAULT);
        axi_wr(8'h08, 32'h3);
        axi_wr(8'h0C, 32'h05292345);
        axi_rd(8'h14, rd, rs);
        check({25'h0, rd[6:0]}, 32'h0);
        check({16'h0, nv_last}, 32'h0000C180);
        request(jdm_pkg::JDM_REQ_DM2);
        wait_hdr(jdm_pkg::JDM_MSG_TP);
        check({last_hdr.dm2, last_hdr.count}, 9'h102);
        request(jdm_pkg::JDM_REQ_DM3);
        // request, a possible broadcast sweep and the clearing sweep
        repeat (400) @(posedge aclk);
        axi_rd(8'h14, rd, rs);
        check({31'h0, rd[9]}, 32'h0);
        give_verdict;
    end
endmodule
